// ===== bench/crt_core_tb.sv
// Self-checking bench for the register transfer control block
`timescale 1ns/10ps
module crt_core_tb;
  import crt_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest, data_bus_oe, acc_onto_bus_en_n, mulquo_onto_bus_en_n;
  logic mulquo_shift_left_en_n, acc_copy_to_mulquo_en_n, dma_active, irq_acknowledge_active;
  logic int_bus_ind_n, io_pause_n, external_io_pulses, int_strobe, run;
  logic next_fetch_n, next_defer_n, next_exec_n, cur_fetch_n, cur_defer_n, cur_exec_n;
  logic load_acc, load_mq, load_mb, load_ma, load_pc;
  logic [3:0] time_state, time_pulse;
  logic [11:0] data_bus_in_n, data_bus_out_n;
  logic state_decode_inhibit_n, irq_request_n, bus_strobe_n, more_transfers_pending_n;
  logic internal_io_n, xfer_type0_n, xfer_type1_n, xfer_type2_n;
  logic [11:0] switch_reg = 12'h000;
  logic stop_n = 1'h1;
  logic cont_key = 1'h0;
  logic addr_load_n = 1'h1;
  logic status_select = 1'h0;
  logic dma_req = 1'h0;
  logic irq_req = 1'h0;
  logic slow_dev = 1'h0;
  logic int_dev = 1'h0;
  logic strobe_req = 1'h0;
  logic [2:0] xfer_kind = 3'h0;
  logic [11:0] data_val = 12'h000;
  logic [31:0] mq_mode [3] = '{32'h20, 32'h10, 32'h30};
  logic [31:0] mq_exp [3] = '{32'h5A5, 32'hB4A, 32'h000};
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  int k;
  always #2.5 clock = ~clock;
  crt_core crt_core_i (.*);
  crt_periph_model crt_periph_model_i (.*);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Waitrequest and read data are taken at the rising edge that ends the wait
  task automatic xfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int w;
    w = 0;
    @(posedge clock);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'h0 && w < 40) begin
      w++;
      @(posedge clock);
    end
    if (avs_waitrequest !== 1'h0) begin
      error_cnt++;
    end
    rdat = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : xfer
  function automatic logic probe(input int sel);
    case (sel)
      0: return load_mq;
      1: return irq_acknowledge_active;
      default: return time_state == 4'h1;
    endcase
  endfunction : probe
  task automatic wait_for(input int sel, input int lim);
    int w;
    w = 0;
    @(negedge clock);
    while (probe(sel) !== 1'h1 && w < lim) begin
      w++;
      @(negedge clock);
    end
    if (probe(sel) !== 1'h1) begin
      error_cnt++;
    end
  endtask : wait_for
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'h1;
    @(negedge clock);
    chk({time_state, run}, 5'h2);
    chk({cur_fetch_n, cur_defer_n, cur_exec_n, data_bus_oe, io_pause_n}, 5'hD);
    xfer(1'h0, IDX_CTRL, 32'h0);
    chk(rdat, {16'h0000, CTRL_RESET});
    xfer(1'h1, 4'hF, 32'h123);
    xfer(1'h0, 4'hF, 32'h0);
    chk(rdat, 32'h0);
    $display("Test reset done");
    // Registers are not bus-writable: load the accumulator by a strobed I/O transfer
    @(posedge clock);
    cont_key <= 1'h1;
    @(posedge clock);
    cont_key <= 1'h0;
    xfer(1'h1, IDX_CTRL, 32'h0080);
    @(posedge clock);
    data_val <= 12'h5A5;
    strobe_req <= 1'h1;
    @(posedge clock);
    strobe_req <= 1'h0;
    stop_n <= 1'h0;
    @(posedge clock);
    stop_n <= 1'h1;
    xfer(1'h1, IDX_CTRL, 32'h0004);
    @(negedge clock);
    chk({acc_onto_bus_en_n, mulquo_onto_bus_en_n, data_bus_oe, data_bus_out_n}, 15'h3A5A);
    xfer(1'h1, IDX_CTRL, 32'h0008);
    @(negedge clock);
    chk({acc_onto_bus_en_n, mulquo_onto_bus_en_n, data_bus_oe, data_bus_out_n}, 15'h5FFF);
    for (k = 0; k < 3; k++) begin
      xfer(1'h1, IDX_CTRL, 32'(k) << 12);
      @(negedge clock);
      chk({next_fetch_n, next_defer_n, next_exec_n}, 3'(~(3'h4 >> k)));
    end
    $display("Test bus and states done");
    @(posedge clock);
    dma_req <= 1'h1;
    @(negedge clock);
    chk(dma_active, 1'h1);
    chk({cur_fetch_n, cur_defer_n, cur_exec_n, next_fetch_n, next_defer_n, next_exec_n},
        6'h3F);
    @(posedge clock);
    dma_req <= 1'h0;
    for (k = 0; k < 4; k++) begin
      @(posedge clock);
      status_select <= k[0];
      irq_req <= k[1];
      @(negedge clock);
      chk(int_bus_ind_n, !(k[0] && k[1]));
    end
    @(posedge clock);
    irq_req <= 1'h0;
    switch_reg <= 12'h6B1;
    addr_load_n <= 1'h0;
    @(posedge clock);
    addr_load_n <= 1'h1;
    xfer(1'h0, IDX_MA, 32'h0);
    chk(rdat, 32'h6B1);
    $display("Test panel and access done");
    @(posedge clock);
    cont_key <= 1'h1;
    @(posedge clock);
    cont_key <= 1'h0;
    @(negedge clock);
    chk(run, 1'h1);
    for (k = 0; k < 3; k++) begin
      xfer(1'h1, IDX_CTRL, mq_mode[k]);
      xfer(1'h1, IDX_LOAD, 32'h02);
      wait_for(0, 300);
      chk({time_state, load_acc, load_pc, load_ma}, 7'h20);
      xfer(1'h0, IDX_MQ, 32'h0);
      chk(rdat, mq_exp[k]);
    end
    $display("Test timing and mux done");
    xfer(1'h1, IDX_CTRL, 32'h0080);
    @(negedge clock);
    chk(io_pause_n, 1'h0);
    // One full memory cycle holds exactly one third time pulse
    for (k = 0; k < 2; k++) begin
      @(posedge clock);
      int_dev <= k[0];
      n = 0;
      repeat (4 * TS_CYCLES) begin
        @(negedge clock);
        n += external_io_pulses;
      end
      chk(n, 1 - k);
    end
    @(posedge clock);
    int_dev <= 1'h0;
    slow_dev <= 1'h1;
    xfer_kind <= 3'h5;
    data_val <= 12'h1E7;
    strobe_req <= 1'h1;
    @(negedge clock);
    chk(int_strobe, 1'h1);
    @(posedge clock);
    strobe_req <= 1'h0;
    @(negedge clock);
    chk(int_strobe, 1'h0);
    xfer(1'h0, IDX_ACC, 32'h0);
    chk(rdat, 32'h1E7);
    xfer(1'h0, IDX_STATUS, 32'h0);
    chk(rdat[20:18], 3'h5);
    // Idle data bus reads as zero: complement adds all ones, zero gate adds nothing
    for (k = 0; k < 2; k++) begin
      xfer(1'h1, IDX_CTRL, 32'h2 + 32'(k));
      xfer(1'h1, IDX_LOAD, 32'h04);
      repeat (250) @(negedge clock);
      xfer(1'h0, IDX_MB, 32'h0);
      chk(rdat, 32'h1E6 + 32'(k));
    end
    xfer(1'h1, IDX_CTRL, 32'h0180);
    @(negedge clock);
    chk(io_pause_n, 1'h1);
    $display("Test io transfer done");
    @(posedge clock);
    slow_dev <= 1'h0;
    irq_req <= 1'h1;
    xfer(1'h1, IDX_CTRL, 32'h8000);
    wait_for(1, 600);
    chk({irq_acknowledge_active, next_exec_n}, 2'h2);
    @(posedge clock);
    irq_req <= 1'h0;
    stop_n <= 1'h0;
    @(posedge clock);
    stop_n <= 1'h1;
    @(negedge clock);
    chk(run, 1'h0);
    wait_for(2, 300);
    repeat (100) @(negedge clock);
    chk({time_state, time_pulse}, 8'h10);
    $display("Test interrupt and stop done");
    wrap_up();
  end
endmodule : crt_core_tb

// ===== bench/crt_periph_model.sv
// Peripheral and DMA option model facing the processor bus
`timescale 1ns/10ps
module crt_periph_model (
  input wire logic io_pause_n,
  input wire logic dma_req,
  input wire logic irq_req,
  input wire logic slow_dev,
  input wire logic int_dev,
  input wire logic strobe_req,
  input wire logic [2:0] xfer_kind,
  input wire logic [11:0] data_val,
  output logic state_decode_inhibit_n,
  output logic irq_request_n,
  output logic bus_strobe_n,
  output logic more_transfers_pending_n,
  output logic internal_io_n,
  output logic xfer_type0_n,
  output logic xfer_type1_n,
  output logic xfer_type2_n,
  output logic [11:0] data_bus_in_n
);
  // ----------------------------------------
  // Bus lines, open drain with pull-ups
  // ----------------------------------------
  logic strobing;
  // Strobe only inside a pause, a stray strobe with transfers pending would clock the interrupt sync
  assign strobing = strobe_req & ~io_pause_n;
  assign state_decode_inhibit_n = ~dma_req;
  assign irq_request_n = ~irq_req;
  assign more_transfers_pending_n = ~slow_dev;
  assign internal_io_n = ~int_dev;
  assign bus_strobe_n = ~strobing;
  // Released lines float to the pull-up level
  assign data_bus_in_n = strobing ? ~data_val : 12'hFFF;
  assign {xfer_type2_n, xfer_type1_n, xfer_type0_n} = io_pause_n ? 3'h7 : ~xfer_kind;
endmodule : crt_periph_model

// ===== hw/crt_core.sv
// Register transfer control, timing, front panel and I/O control of the processor
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
// What this block does
// - Adder operand is data bus, its complement or zero, by true/false gates.
// - Zero operand never selected during operate instruction in third time state.
// - Data bus driven from accumulator or multiplier-quotient, each by low enable.
// - MQ mux: shift-left, copy accumulator, or zero when both enables are high or both low.
// - Low next-state and low current-state fetch, defer, execute indications.
// - DMA state asserted whenever state-decode inhibit line is low.
// - Acknowledge raises in-progress, forcing subroutine jump opcode and execute state.
// - User mode blocks halt, I/O pause, switch OR and load from switches.
// - Status selector on status shows interrupt request on the indicator.
// - Distinct load strobe for each major register whenever it is written.
// - Interrupt strobe from bus strobe with pending transfers, else pulse three.
// - Low I/O pause during I/O instructions, also used for own decoding.
// - Low bus strobe loads returned data into accumulator or program counter.
// - Internal I/O line inhibits external I/O pulses.
// - Stop clears run flip-flop; timing then halts at first time state.
// - Continue key starts automatic free-running timing.
// - Address-load key loads switch address into memory address register.
// - Each memory cycle steps four time states with four time pulses.
// - Data bus is 12 bits, active low.
module crt_core (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [crt_pkg::WORD_W-1:0] data_bus_in_n,
  output logic [crt_pkg::WORD_W-1:0] data_bus_out_n,
  output logic data_bus_oe,
  output logic acc_onto_bus_en_n,
  output logic mulquo_onto_bus_en_n,
  output logic mulquo_shift_left_en_n,
  output logic acc_copy_to_mulquo_en_n,
  input wire logic [crt_pkg::WORD_W-1:0] switch_reg,
  input wire logic state_decode_inhibit_n,
  input wire logic irq_request_n,
  input wire logic bus_strobe_n,
  input wire logic more_transfers_pending_n,
  input wire logic internal_io_n,
  input wire logic xfer_type0_n,
  input wire logic xfer_type1_n,
  input wire logic xfer_type2_n,
  input wire logic stop_n,
  input wire logic cont_key,
  input wire logic addr_load_n,
  input wire logic status_select,
  output logic dma_active,
  output logic irq_acknowledge_active,
  output logic int_bus_ind_n,
  output logic io_pause_n,
  output logic external_io_pulses,
  output logic int_strobe,
  output logic next_fetch_n,
  output logic next_defer_n,
  output logic next_exec_n,
  output logic cur_fetch_n,
  output logic cur_defer_n,
  output logic cur_exec_n,
  output logic [3:0] time_state,
  output logic [3:0] time_pulse,
  output logic run,
  output logic load_acc,
  output logic load_mq,
  output logic load_mb,
  output logic load_ma,
  output logic load_pc
);
  import crt_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl_reg;
  logic [LD_W-1:0] pend_reg;
  logic [WORD_W-1:0] main_arith_register;
  logic [WORD_W-1:0] multiplier_quotient_reg;
  logic [WORD_W-1:0] memory_buffer_reg;
  logic [WORD_W-1:0] cpu_memory_address_reg;
  logic [WORD_W-1:0] program_counter;
  logic [WORD_W-1:0] instruction_register;
  logic [TCNT_W-1:0] tcnt_reg;
  crt_time_state_type ts_reg;
  crt_major_state_type ms_reg;
  logic run_reg;
  logic int_sync_reg;
  logic ack_reg;
  logic bus_ack_reg;
  logic [31:0] rdata_reg;
  logic [2:0] xfer_type_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req = avs_read | avs_write;
  wire take = req & bus_ack_reg;
  wire wr_ctrl = take & avs_write & (avs_address == IDX_CTRL);
  wire wr_load = take & avs_write & (avs_address == IDX_LOAD);
  assign avs_waitrequest = req & ~bus_ack_reg;
  assign avs_readdata = rdata_reg;

  // ----------------------------------------
  // Timing generator
  // ----------------------------------------
  wire ts_end = (tcnt_reg == TCNT_LAST);
  // Holding in the first state keeps every halt on a clean cycle boundary
  wire ts_hold = (ts_reg == TS_ONE) & ~run_reg;
  wire tp_any = ts_end & ~ts_hold;
  wire tp1 = tp_any & (ts_reg == TS_ONE);
  wire tp2 = tp_any & (ts_reg == TS_TWO);
  wire tp3 = tp_any & (ts_reg == TS_THREE);
  wire tp4 = tp_any & (ts_reg == TS_FOUR);
  assign time_state = ts_reg;
  assign time_pulse = {tp4, tp3, tp2, tp1};
  assign run = run_reg;

  crt_time_state_type ts_next;
  always_comb begin
    ts_next = ts_reg;
    if (tp_any) begin
      case (ts_reg)
        TS_ONE: ts_next = TS_TWO;
        TS_TWO: ts_next = TS_THREE;
        TS_THREE: ts_next = TS_FOUR;
        default: ts_next = TS_ONE;
      endcase
    end
  end

  wire user_mode = ctrl_reg[C_USER];
  wire halt_ok = ctrl_reg[C_HALT] & ~user_mode;
  wire run_next = ~stop_n ? 1'b0 :
    (cont_key ? 1'b1 : (halt_ok ? 1'b0 : run_reg));

  // ----------------------------------------
  // Operand gating and multiplexers
  // ----------------------------------------
  wire [WORD_W-1:0] data_val = ~data_bus_in_n;
  wire gate_t = ctrl_reg[C_GATE_T];
  wire gate_f = ctrl_reg[C_GATE_F];
  wire op_ts3 = ctrl_reg[C_OPERATE] & (ts_reg == TS_THREE);
  // Zero request in the forbidden slot falls back to the plain bus value
  wire sel_zero = gate_t & gate_f & ~op_ts3;
  wire sel_compl = ~gate_t & gate_f;
  wire [WORD_W-1:0] operand = sel_zero ? WORD_ZERO :
    (sel_compl ? ~data_val : data_val);
  wire [WORD_W-1:0] adder_out = main_arith_register + operand;

  assign acc_onto_bus_en_n = ~ctrl_reg[C_ACC_BUS];
  assign mulquo_onto_bus_en_n = ~ctrl_reg[C_MQ_BUS];
  assign data_bus_oe = ~acc_onto_bus_en_n | ~mulquo_onto_bus_en_n;
  assign data_bus_out_n = ~acc_onto_bus_en_n ? ~main_arith_register :
    (~mulquo_onto_bus_en_n ? ~multiplier_quotient_reg : {WORD_W{1'b1}});

  assign mulquo_shift_left_en_n = ~ctrl_reg[C_SHL];
  assign acc_copy_to_mulquo_en_n = ~ctrl_reg[C_COPY];
  wire mq_shl = ~mulquo_shift_left_en_n & acc_copy_to_mulquo_en_n;
  wire mq_copy = mulquo_shift_left_en_n & ~acc_copy_to_mulquo_en_n;
  wire [WORD_W-1:0] mq_mux = mq_shl ? {multiplier_quotient_reg[WORD_W-2:0], 1'b0} :
    (mq_copy ? main_arith_register : WORD_ZERO);

  // ----------------------------------------
  // I/O transfer control
  // ----------------------------------------
  assign io_pause_n = ~(ctrl_reg[C_IOT] & ~user_mode & run_reg);
  assign external_io_pulses = ~io_pause_n & tp3 & internal_io_n;
  wire strobe_load = ~io_pause_n & ~bus_strobe_n;
  assign int_strobe = ~more_transfers_pending_n ? ~bus_strobe_n : tp3;
  assign int_bus_ind_n = ~(status_select & ~irq_request_n);
  assign dma_active = ~state_decode_inhibit_n;
  assign irq_acknowledge_active = ack_reg;
  wire las_ok = ctrl_reg[C_LAS] & ~user_mode & tp3;
  wire osr_ok = ctrl_reg[C_OSR] & ~user_mode & tp3;
  wire ack_set = tp4 & int_sync_reg & ctrl_reg[C_INT_EN] & state_decode_inhibit_n;

  // ----------------------------------------
  // Load strobes
  // ----------------------------------------
  wire iot_to_pc = ctrl_reg[C_IOT_PC];
  assign load_acc = (pend_reg[0] & tp3) | (strobe_load & ~iot_to_pc) | las_ok | osr_ok;
  assign load_mq = pend_reg[1] & tp3;
  assign load_mb = pend_reg[2] & tp2;
  assign load_ma = (pend_reg[3] & tp1) | ~addr_load_n;
  assign load_pc = (pend_reg[4] & tp3) | (strobe_load & iot_to_pc);
  wire [LD_W-1:0] fired = {load_pc, load_ma, load_mb, load_mq, load_acc};
  wire [LD_W-1:0] ld_wr = wr_load ? avs_writedata[LD_W-1:0] : LD_NONE;
  // A request written in its firing cycle stays pending for the next pulse
  wire [LD_W-1:0] pend_next = (pend_reg & ~fired) | ld_wr;

  wire [WORD_W-1:0] acc_next = strobe_load ? data_val :
    (las_ok ? switch_reg : (osr_ok ? (main_arith_register | switch_reg) : adder_out));
  wire [WORD_W-1:0] ma_next = ~addr_load_n ? switch_reg : adder_out;
  wire [WORD_W-1:0] pc_next = strobe_load ? data_val : adder_out;

  // ----------------------------------------
  // Major state
  // ----------------------------------------
  wire [1:0] next_code = ctrl_reg[C_NEXT_LO +: 2];
  crt_major_state_type ms_pick;
  always_comb begin
    case (next_code)
      NEXT_DEFER: ms_pick = MS_DEFER;
      NEXT_EXEC: ms_pick = MS_EXEC;
      default: ms_pick = MS_FETCH;
    endcase
    if (ack_reg) begin
      ms_pick = MS_EXEC;
    end
  end
  wire inhibit = ~state_decode_inhibit_n;
  assign next_fetch_n = inhibit | (ms_pick != MS_FETCH);
  assign next_defer_n = inhibit | (ms_pick != MS_DEFER);
  assign next_exec_n = inhibit | (ms_pick != MS_EXEC);
  assign cur_fetch_n = inhibit | (ms_reg != MS_FETCH);
  assign cur_defer_n = inhibit | (ms_reg != MS_DEFER);
  assign cur_exec_n = inhibit | (ms_reg != MS_EXEC);
  // Forced jump waits out a DMA window too, the option owns the cycle
  wire ir_load = (ack_reg | (tp2 & (ms_reg == MS_FETCH))) & ~inhibit;
  wire [WORD_W-1:0] ir_next = ack_reg ? JUMP_TO_SUBROUTINE_OP : memory_buffer_reg;

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  wire [31:0] status_word = {11'h000, xfer_type_reg, int_sync_reg, ack_reg, dma_active,
    run_reg, ms_reg, ts_reg, tcnt_reg};
  wire [31:0] rd_next = (avs_address == IDX_CTRL) ? {16'h0000, ctrl_reg} :
    (avs_address == IDX_LOAD) ? {27'h0000000, pend_reg} :
    (avs_address == IDX_ACC) ? {20'h00000, main_arith_register} :
    (avs_address == IDX_MQ) ? {20'h00000, multiplier_quotient_reg} :
    (avs_address == IDX_MB) ? {20'h00000, memory_buffer_reg} :
    (avs_address == IDX_MA) ? {20'h00000, cpu_memory_address_reg} :
    (avs_address == IDX_PC) ? {20'h00000, program_counter} :
    (avs_address == IDX_IR) ? {20'h00000, instruction_register} :
    (avs_address == IDX_STATUS) ? status_word : 32'h00000000;

  // ----------------------------------------
  // Flip-flops
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      ctrl_reg <= CTRL_RESET;
      pend_reg <= LD_NONE;
    end else begin
      bus_ack_reg <= req & ~bus_ack_reg;
      rdata_reg <= (avs_read & ~bus_ack_reg) ? rd_next : rdata_reg;
      ctrl_reg <= wr_ctrl ? avs_writedata[CTRL_W-1:0] : ctrl_reg;
      pend_reg <= pend_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tcnt_reg <= TCNT_ZERO;
      ts_reg <= TS_ONE;
      run_reg <= 1'b0;
    end else begin
      tcnt_reg <= (ts_hold | ts_end) ? TCNT_ZERO : tcnt_reg + 7'h01;
      ts_reg <= ts_next;
      run_reg <= run_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      int_sync_reg <= 1'b0;
      ack_reg <= 1'b0;
      ms_reg <= MS_FETCH;
      xfer_type_reg <= 3'h0;
    end else begin
      int_sync_reg <= int_strobe ? ~irq_request_n : int_sync_reg;
      ack_reg <= ack_set | (ack_reg & ~tp4);
      ms_reg <= (tp4 & ~inhibit) ? ms_pick : ms_reg;
      xfer_type_reg <= ~io_pause_n ? ~{xfer_type2_n, xfer_type1_n, xfer_type0_n} : xfer_type_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      main_arith_register <= WORD_ZERO;
      multiplier_quotient_reg <= WORD_ZERO;
      memory_buffer_reg <= WORD_ZERO;
      cpu_memory_address_reg <= WORD_ZERO;
      program_counter <= WORD_ZERO;
      instruction_register <= WORD_ZERO;
    end else begin
      main_arith_register <= load_acc ? acc_next : main_arith_register;
      multiplier_quotient_reg <= load_mq ? mq_mux : multiplier_quotient_reg;
      memory_buffer_reg <= load_mb ? adder_out : memory_buffer_reg;
      cpu_memory_address_reg <= load_ma ? ma_next : cpu_memory_address_reg;
      program_counter <= load_pc ? pc_next : program_counter;
      instruction_register <= ir_load ? ir_next : instruction_register;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_zero_slot_blocked: assert property (op_ts3 |-> operand == data_val || sel_compl)
    else $error("zero operand in operate third state");
  a_operand_compl: assert property (sel_compl |-> operand == ~data_val)
    else $error("complement operand wrong");
  a_bus_acc_drive: assert property (!acc_onto_bus_en_n |->
    data_bus_oe && data_bus_out_n == ~main_arith_register)
    else $error("accumulator not on data bus");
  a_mq_shift_load: assert property (load_mq && mq_shl |=>
    multiplier_quotient_reg == {$past(multiplier_quotient_reg[WORD_W-2:0]), 1'b0})
    else $error("mq shift left wrong");
  a_dma_follows: assert property (!state_decode_inhibit_n |->
    dma_active && cur_fetch_n && cur_defer_n && cur_exec_n && !ir_load)
    else $error("major state visible during dma");
  a_ack_forces_jms: assert property ($rose(ack_reg) |=>
    instruction_register == JUMP_TO_SUBROUTINE_OP && !next_exec_n || inhibit)
    else $error("acknowledge did not force jump and execute");
  a_user_blocks_io: assert property (user_mode |-> io_pause_n && !las_ok && !osr_ok)
    else $error("user mode let a blocked operation through");
  a_stop_clears_run: assert property (!stop_n |=> !run_reg)
    else $error("stop did not clear run");
  a_halt_at_first: assert property (!run_reg && ts_reg == TS_ONE |=> ts_reg == TS_ONE)
    else $error("timing did not halt in first state");
  a_ts_sequence: assert property (tp1 |=> ts_reg == TS_TWO ##[59:60] ts_reg == TS_THREE)
    else $error("time state order broken");
  a_external_io_pulses_inhibited: assert property (!internal_io_n |-> !external_io_pulses)
    else $error("external pulse while internal io");
  a_int_indicator: assert property (status_select && !irq_request_n |-> !int_bus_ind_n)
    else $error("interrupt indicator not lit");
  a_strobe_acc: assert property (strobe_load && !iot_to_pc |=> main_arith_register == $past(data_val))
    else $error("bus strobe did not load accumulator");
  a_addr_load: assert property (!addr_load_n |=> cpu_memory_address_reg == $past(switch_reg))
    else $error("address load failed");

  c_full_cycle: cover property (tp1 ##[1:300] tp4);
  c_irq_ack: cover property ($rose(ack_reg));
  c_io_strobe: cover property (!io_pause_n ##[1:100] strobe_load);
  c_dma_window: cover property (!state_decode_inhibit_n ##1 state_decode_inhibit_n);
endmodule : crt_core

// ===== pkg/crt_pkg.sv
// Constants, field layouts and state types of the register transfer control block
package crt_pkg;
  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int unsigned WORD_W = 12;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TIME_STATE_NS = 300;
  localparam int unsigned TS_CYCLES = (TIME_STATE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TCNT_W = 7;
  localparam logic [TCNT_W-1:0] TCNT_LAST = TCNT_W'(TS_CYCLES - 1);
  localparam logic [TCNT_W-1:0] TCNT_ZERO = 7'h00;
  localparam logic [11:0] WORD_ZERO = 12'h000;
  localparam logic [11:0] JUMP_TO_SUBROUTINE_OP = 12'h800;
  // ----------------------------------------
  // Register word indices
  // ----------------------------------------
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_LOAD = 4'h1;
  localparam logic [3:0] IDX_ACC = 4'h2;
  localparam logic [3:0] IDX_MQ = 4'h3;
  localparam logic [3:0] IDX_MB = 4'h4;
  localparam logic [3:0] IDX_MA = 4'h5;
  localparam logic [3:0] IDX_PC = 4'h6;
  localparam logic [3:0] IDX_IR = 4'h7;
  localparam logic [3:0] IDX_STATUS = 4'h8;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int unsigned C_GATE_T = 0;
  localparam int unsigned C_GATE_F = 1;
  localparam int unsigned C_ACC_BUS = 2;
  localparam int unsigned C_MQ_BUS = 3;
  localparam int unsigned C_SHL = 4;
  localparam int unsigned C_COPY = 5;
  localparam int unsigned C_OPERATE = 6;
  localparam int unsigned C_IOT = 7;
  localparam int unsigned C_USER = 8;
  localparam int unsigned C_HALT = 9;
  localparam int unsigned C_OSR = 10;
  localparam int unsigned C_LAS = 11;
  localparam int unsigned C_NEXT_LO = 12;
  localparam int unsigned C_IOT_PC = 14;
  localparam int unsigned C_INT_EN = 15;
  localparam int unsigned CTRL_W = 16;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0030;
  localparam logic [1:0] NEXT_FETCH = 2'h0;
  localparam logic [1:0] NEXT_DEFER = 2'h1;
  localparam logic [1:0] NEXT_EXEC = 2'h2;
  localparam int unsigned LD_W = 5;
  localparam logic [LD_W-1:0] LD_NONE = 5'h00;
  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [3:0] {
    TS_ONE = 4'b0001, TS_TWO = 4'b0010, TS_THREE = 4'b0100, TS_FOUR = 4'b1000
  } crt_time_state_type;
  typedef enum logic [2:0] {
    MS_FETCH = 3'b001, MS_DEFER = 3'b010, MS_EXEC = 3'b100
  } crt_major_state_type;
endpackage : crt_pkg
